/* File: rtl/opsc_pkg.sv */
// Behaviour
// - Bit 7 sets supply-enable pin polarity
// - Bit 6 sets fault pin polarity
// - Bit 5 sets output-good pin polarity
// - Bit 4 sets mains-good pin polarity
// - Bit 3 sets pass-gate polarity, 1 normal
// - Bit 2 lets host force share clamp
// - Bit 1 lets host drive fault pin
// - Bit 0 lets host clear latched fault
// - Register 14h holds divider error trim
// - Register 15h holds sense DC offset trim
// - 17h bit 6 selects chopper amplifier
// - 17h bit 4 zeroes ground offset
// - Registers load from nonvolatile copy at power-up
// - Latch mode bit: 0 follows, 1 latches
package opsc_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0]  OFS_OUT_POL    = 8'h13;
    localparam logic [7:0]  OFS_DIV_TRIM   = 8'h14;
    localparam logic [7:0]  OFS_DC_TRIM    = 8'h15;
    localparam logic [7:0]  OFS_SENSE_ONE  = 8'h16;
    localparam logic [7:0]  OFS_SENSE_TWO  = 8'h17;
    localparam int          NUM_REGS       = 5;
    localparam logic [2:0]  IDX_OUT_POL    = 3'h0;
    localparam logic [2:0]  IDX_DIV_TRIM   = 3'h1;
    localparam logic [2:0]  IDX_DC_TRIM    = 3'h2;
    localparam logic [2:0]  IDX_SENSE_ONE  = 3'h3;
    localparam logic [2:0]  IDX_SENSE_TWO  = 3'h4;
    localparam logic [2:0]  IDX_LAST       = 3'h4;
    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
    // ==========================================
    // Nonvolatile copy
    localparam logic [15:0] NV_BASE        = 16'h8113;
    // ==========================================
    // Output configuration fields
    localparam int          BIT_SUPPLY_POL = 7;
    localparam int          BIT_FAULT_POL  = 6;
    localparam int          BIT_OKOUT_POL  = 5;
    localparam int          BIT_MAINS_POL  = 4;
    localparam int          BIT_GATE_POL   = 3;
    localparam int          BIT_CLAMP      = 2;
    localparam int          BIT_FAULT_DRV  = 1;
    localparam int          BIT_FAULT_CLR  = 0;
    // ==========================================
    // Sense option fields
    localparam int          DIV_SEL_HI     = 5;
    localparam int          DIV_SEL_LO     = 3;
    localparam int          BIT_XFORMER    = 7;
    localparam int          BIT_CHOPPER    = 6;
    localparam int          BIT_GND_ZERO   = 4;
    localparam int          DIFF_SEL_HI    = 2;
    localparam int          DIFF_SEL_LO    = 0;
    // ==========================================
    // Trim magnitudes in mV
    localparam logic signed [6:0] DIV_MV_1  = 7'sh05;
    localparam logic signed [6:0] DIV_MV_2  = 7'sh0A;
    localparam logic signed [6:0] DIV_MV_3  = 7'sh14;
    localparam logic signed [6:0] DIFF_MV_1 = 7'sh08;
    localparam logic signed [6:0] DIFF_MV_2 = 7'sh0F;
    localparam logic signed [6:0] DIFF_MV_3 = 7'sh1E;
    localparam logic signed [6:0] MV_NONE   = 7'sh00;

    typedef enum logic [2:0] {
        LD_FETCH   = 3'b001,
        LD_CAPTURE = 3'b010,
        LD_DONE    = 3'b100
    } opsc_ld_state_t;
endpackage : opsc_pkg

/* File: rtl/opsc_pin_polarity.sv */
`timescale 1ns/10ps
module opsc_pin_polarity #(
    parameter int N = 4
) (
    input  wire logic         mclk_in,
    input  wire logic         srst_in,
    input  wire logic [N-1:0] level_in,
    input  wire logic [N-1:0] pol_in,
    output logic      [N-1:0] pin_out
);
    import opsc_pkg::*;

    wire logic [N-1:0] pin_d;

    // ==========================================
    // Polarity per pin, 1 = active high
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            assign pin_d[i] = ~(level_in[i] ^ pol_in[i]);
        end
    endgenerate

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pin_out <= {N{1'b0}};
        end else begin
            pin_out <= pin_d;
        end
    end
endmodule : opsc_pin_polarity

/* File: rtl/opsc_nv_loader.sv */
`timescale 1ns/10ps
module opsc_nv_loader (
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  nv_rdata_in,
    output logic             nv_rd_en_out,
    output logic      [15:0] nv_addr_out,
    output logic             ld_we_out,
    output logic      [2:0]  ld_idx_out,
    output logic      [7:0]  ld_data_out,
    output logic             busy_out
);
    import opsc_pkg::*;

    opsc_ld_state_t state_q;
    logic [2:0]     idx_q;

    // ==========================================
    // Walk nonvolatile copies after reset
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_q <= LD_FETCH;
            idx_q   <= 3'h0;
        end else begin
            unique case (state_q)
                LD_FETCH: begin
                    state_q <= LD_CAPTURE;
                end
                LD_CAPTURE: begin
                    if (idx_q == IDX_LAST) begin
                        state_q <= LD_DONE;
                    end else begin
                        state_q <= LD_FETCH;
                        idx_q   <= idx_q + 3'h1;
                    end
                end
                LD_DONE: begin
                    state_q <= LD_DONE;
                end
            endcase
        end
    end

    // ==========================================
    // Registered strobes toward memory and bank
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            nv_rd_en_out <= 1'b0;
            nv_addr_out  <= NV_BASE;
            ld_we_out    <= 1'b0;
            ld_idx_out   <= 3'h0;
            ld_data_out  <= REG_RESET;
            busy_out     <= 1'b1;
        end else begin
            nv_rd_en_out <= (state_q == LD_FETCH);
            nv_addr_out  <= NV_BASE + {13'h0000, idx_q};
            ld_we_out    <= (state_q == LD_CAPTURE);
            ld_idx_out   <= idx_q;
            ld_data_out  <= nv_rdata_in;
            busy_out     <= (state_q != LD_DONE) || ld_we_out;
        end
    end
endmodule : opsc_nv_loader

/* File: rtl/opsc_config_bank.sv */
`timescale 1ns/10ps
module opsc_config_bank (
    input  wire logic              mclk_in,
    input  wire logic              srst_in,
    input  wire logic              host_wr_en_in,
    input  wire logic              host_rd_en_in,
    input  wire logic [7:0]        host_addr_in,
    input  wire logic [7:0]        host_wdata_in,
    output logic      [7:0]        host_rdata_out,
    output logic                   host_rvalid_out,
    output logic                   cfg_busy_out,
    output logic                   nv_rd_en_out,
    output logic      [15:0]       nv_addr_out,
    input  wire logic [7:0]        nv_rdata_in,
    input  wire logic              supply_enable_req_in,
    input  wire logic              fault_event_in,
    input  wire logic              fault_latch_mode_in,
    input  wire logic              output_good_req_in,
    input  wire logic              mains_good_req_in,
    input  wire logic              gate_on_req_in,
    input  wire logic              share_clamp_req_in,
    output logic                   supply_enable_out,
    output logic                   fault_indicator_out,
    output logic                   output_good_out,
    output logic                   mains_good_out,
    output logic                   pass_gate_out,
    output logic                   share_clamp_out,
    output logic                   fault_latched_out,
    output logic      [7:0]        divider_error_trim_out,
    output logic      [7:0]        sense_dc_offset_trim_out,
    output logic signed [6:0]      divider_trim_mv_out,
    output logic signed [6:0]      diff_trim_mv_out,
    output logic                   sense_xformer_mode_out,
    output logic                   chopper_en_out,
    output logic                   ground_offset_zero_out
);
    import opsc_pkg::*;

    // ==========================================
    // Decoders
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a >= OFS_OUT_POL) && (a <= OFS_SENSE_TWO);
    endfunction : addr_hit

    function automatic logic [2:0] addr_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - OFS_OUT_POL;
        addr_idx = d[2:0];
    endfunction : addr_idx

    function automatic logic signed [6:0] trim_mv(input logic [2:0] code,
                                                  input logic signed [6:0] m1,
                                                  input logic signed [6:0] m2,
                                                  input logic signed [6:0] m3);
        logic signed [6:0] mag;
        mag = MV_NONE;
        unique case (code[1:0])
            2'b00:   mag = m1;
            2'b01:   mag = m2;
            2'b10:   mag = m3;
            default: mag = MV_NONE;
        endcase
        trim_mv = code[2] ? mag : -mag;
    endfunction : trim_mv

    // ==========================================
    // Register storage
    logic [7:0] cfg_q [NUM_REGS];
    logic       ld_we;
    logic [2:0] ld_idx;
    logic [7:0] ld_data;
    logic       host_we;
    logic       fault_latched_q;
    logic       fault_latched_d;
    logic       fault_active;
    logic [7:0] pol_reg;

    assign host_we = host_wr_en_in && !cfg_busy_out && addr_hit(host_addr_in);
    assign pol_reg = cfg_q[IDX_OUT_POL];

    opsc_nv_loader u_loader (
        .mclk_in      (mclk_in),
        .srst_in      (srst_in),
        .nv_rdata_in  (nv_rdata_in),
        .nv_rd_en_out (nv_rd_en_out),
        .nv_addr_out  (nv_addr_out),
        .ld_we_out    (ld_we),
        .ld_idx_out   (ld_idx),
        .ld_data_out  (ld_data),
        .busy_out     (cfg_busy_out)
    );

    // Power-up load, then host writes; all bits stored
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            for (int k = 0; k < NUM_REGS; k++) begin
                cfg_q[k] <= REG_RESET;
            end
        end else if (ld_we) begin
            cfg_q[ld_idx] <= ld_data;
        end else if (host_we) begin
            cfg_q[addr_idx(host_addr_in)] <= host_wdata_in;
        end
    end

    // ==========================================
    // Read port
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            host_rdata_out  <= UNMAPPED_READ;
            host_rvalid_out <= 1'b0;
        end else begin
            host_rvalid_out <= host_rd_en_in;
            if (host_rd_en_in && addr_hit(host_addr_in)) begin
                host_rdata_out <= cfg_q[addr_idx(host_addr_in)];
            end else begin
                host_rdata_out <= UNMAPPED_READ;
            end
        end
    end

    // ==========================================
    // Fault latch, event wins over clear
    assign fault_latched_d = fault_latch_mode_in && (fault_event_in ||
                             (fault_latched_q && !pol_reg[BIT_FAULT_CLR]));
    assign fault_active = pol_reg[BIT_FAULT_DRV] || fault_event_in ||
                          fault_latched_q;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            fault_latched_q <= 1'b0;
        end else begin
            fault_latched_q <= fault_latched_d;
        end
    end

    // ==========================================
    // Status pins with polarity
    opsc_pin_polarity #(.N(4)) u_pins (
        .mclk_in  (mclk_in),
        .srst_in  (srst_in),
        .level_in ({supply_enable_req_in, fault_active,
                    output_good_req_in, mains_good_req_in}),
        .pol_in   ({pol_reg[BIT_SUPPLY_POL], pol_reg[BIT_FAULT_POL],
                    pol_reg[BIT_OKOUT_POL], pol_reg[BIT_MAINS_POL]}),
        .pin_out  ({supply_enable_out, fault_indicator_out,
                    output_good_out, mains_good_out})
    );

    // ==========================================
    // Gate, clamp and sense controls
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pass_gate_out     <= 1'b0;
            share_clamp_out   <= 1'b0;
            fault_latched_out <= 1'b0;
        end else begin
            pass_gate_out     <= pol_reg[BIT_GATE_POL] ? gate_on_req_in
                                                       : !gate_on_req_in;
            share_clamp_out   <= pol_reg[BIT_CLAMP] || share_clamp_req_in;
            fault_latched_out <= fault_latched_q;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            divider_error_trim_out   <= REG_RESET;
            sense_dc_offset_trim_out <= REG_RESET;
            divider_trim_mv_out      <= MV_NONE;
            diff_trim_mv_out         <= MV_NONE;
            sense_xformer_mode_out   <= 1'b0;
            chopper_en_out           <= 1'b0;
            ground_offset_zero_out   <= 1'b0;
        end else begin
            divider_error_trim_out   <= cfg_q[IDX_DIV_TRIM];
            sense_dc_offset_trim_out <= cfg_q[IDX_DC_TRIM];
            divider_trim_mv_out      <= trim_mv(cfg_q[IDX_SENSE_ONE][DIV_SEL_HI:DIV_SEL_LO],
                                                DIV_MV_1, DIV_MV_2, DIV_MV_3);
            diff_trim_mv_out         <= trim_mv(cfg_q[IDX_SENSE_TWO][DIFF_SEL_HI:DIFF_SEL_LO],
                                                DIFF_MV_1, DIFF_MV_2, DIFF_MV_3);
            sense_xformer_mode_out   <= cfg_q[IDX_SENSE_TWO][BIT_XFORMER];
            chopper_en_out           <= cfg_q[IDX_SENSE_TWO][BIT_CHOPPER];
            ground_offset_zero_out   <= cfg_q[IDX_SENSE_TWO][BIT_GND_ZERO];
        end
    end

    // ==========================================
    // Checks
    // Checks start one edge after reset ends
    logic run_q;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            run_q <= 1'b0;
        end else begin
            run_q <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in || !run_q);

    supply_pol_a: assert property (
        ##1 supply_enable_out == ($past(pol_reg[BIT_SUPPLY_POL]) ?
            $past(supply_enable_req_in) : !$past(supply_enable_req_in)))
        else $error("supply enable polarity wrong");
    fault_drive_a: assert property (
        pol_reg[BIT_FAULT_DRV] |=> fault_indicator_out == $past(pol_reg[BIT_FAULT_POL]))
        else $error("host fault drive not seen on pin");
    fault_pol_a: assert property (
        !fault_active && !pol_reg[BIT_FAULT_POL] |=> fault_indicator_out)
        else $error("idle fault pin wrong for low polarity");
    okout_pol_a: assert property (
        ##1 output_good_out == ($past(pol_reg[BIT_OKOUT_POL]) ~^ $past(output_good_req_in)))
        else $error("output good polarity wrong");
    mains_pol_a: assert property (
        ##1 mains_good_out == ($past(pol_reg[BIT_MAINS_POL]) ~^ $past(mains_good_req_in)))
        else $error("mains good polarity wrong");
    gate_pol_a: assert property (
        !pol_reg[BIT_GATE_POL] && gate_on_req_in |=> !pass_gate_out)
        else $error("inverted gate not low when on");
    clamp_force_a: assert property (
        pol_reg[BIT_CLAMP] |=> share_clamp_out)
        else $error("share clamp not forced");
    latch_clear_a: assert property (
        fault_latched_q && pol_reg[BIT_FAULT_CLR] && !fault_event_in |=> !fault_latched_q)
        else $error("latched fault not cleared");
    latch_hold_a: assert property (
        fault_latch_mode_in && fault_event_in ##1 fault_latch_mode_in &&
        !pol_reg[BIT_FAULT_CLR] |-> fault_latched_q)
        else $error("fault did not latch");
    nolatch_a: assert property (
        !fault_latch_mode_in |=> !fault_latched_q)
        else $error("latch set in follow mode");
    trim_copy_a: assert property (
        ##2 divider_error_trim_out == $past(cfg_q[IDX_DIV_TRIM], 1))
        else $error("divider trim not presented");
    dc_copy_a: assert property (
        ##1 sense_dc_offset_trim_out == $past(cfg_q[IDX_DC_TRIM]))
        else $error("dc offset trim not presented");
    div_range_a: assert property (
        cfg_q[IDX_SENSE_ONE][DIV_SEL_HI:DIV_SEL_LO] == 3'h2 |=> divider_trim_mv_out == -DIV_MV_3)
        else $error("divider range decode wrong");
    diff_range_a: assert property (
        cfg_q[IDX_SENSE_TWO][DIFF_SEL_HI:DIFF_SEL_LO] == 3'h4 |=> diff_trim_mv_out == DIFF_MV_1)
        else $error("diff range decode wrong");
    chopper_a: assert property (
        ##1 chopper_en_out == $past(cfg_q[IDX_SENSE_TWO][BIT_CHOPPER]))
        else $error("chopper select wrong");
    gnd_zero_a: assert property (
        ##1 ground_offset_zero_out == $past(cfg_q[IDX_SENSE_TWO][BIT_GND_ZERO]))
        else $error("ground offset select wrong");
    nv_load_a: assert property (
        ld_we && ld_idx == IDX_OUT_POL |=> pol_reg == $past(ld_data))
        else $error("nonvolatile copy not loaded");
    reserved_a: assert property (
        host_we && host_addr_in == OFS_SENSE_ONE |=> cfg_q[IDX_SENSE_ONE] == $past(host_wdata_in))
        else $error("reserved bits not stored");

    wr_refused_a: assert property (
        cfg_busy_out && !ld_we && host_wr_en_in |=>
        cfg_q[IDX_OUT_POL] == $past(cfg_q[IDX_OUT_POL]))
        else $error("write taken while loading");
    rd_valid_a: assert property (
        host_rd_en_in |=> host_rvalid_out)
        else $error("read answer missing");
    rd_data_a: assert property (
        host_rd_en_in && host_addr_in == OFS_SENSE_ONE |=>
        host_rdata_out == $past(cfg_q[IDX_SENSE_ONE]))
        else $error("read data not register contents");
    rd_unmapped_a: assert property (
        host_rd_en_in && !addr_hit(host_addr_in) |=> host_rdata_out == UNMAPPED_READ)
        else $error("unmapped read not zero");
    clamp_req_a: assert property (
        share_clamp_req_in |=> share_clamp_out)
        else $error("share clamp request lost");
    gate_norm_a: assert property (
        pol_reg[BIT_GATE_POL] |=> pass_gate_out == $past(gate_on_req_in))
        else $error("normal gate not following request");
    latch_out_a: assert property (
        ##1 fault_latched_out == $past(fault_latched_q))
        else $error("latch state not presented");
    xformer_a: assert property (
        ##1 sense_xformer_mode_out == $past(cfg_q[IDX_SENSE_TWO][BIT_XFORMER]))
        else $error("sense mode select wrong");

    // ==========================================
    // Cover points
    load_done_c: cover property ($fell(cfg_busy_out));
    latched_c:   cover property (fault_latched_q ##1 !fault_latched_q);
    host_wr_c:   cover property (host_we ##1 host_rd_en_in);
    refused_c:   cover property (cfg_busy_out && host_wr_en_in);
    clamp_req_c: cover property (share_clamp_req_in && !pol_reg[BIT_CLAMP] ##1 share_clamp_out);
endmodule : opsc_config_bank

/* File: dv/opsc_nv_model.sv */
`timescale 1ns/10ps
// ==========================================
// Nonvolatile store seen by the power-up loader
module opsc_nv_model
    import opsc_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        nv_rd_en_in,
    input  wire logic [15:0] nv_addr_in,
    output logic      [7:0]  nv_rdata_out
);
    logic [7:0]  mem_q [0:4];
    logic [7:0]  idle_q;
    logic [15:0] idx;

    assign idx = nv_addr_in - NV_BASE;

    initial begin
        mem_q[0]     = 8'hC8;
        mem_q[1]     = 8'h5A;
        mem_q[2]     = 8'h3C;
        mem_q[3]     = 8'hCA;
        mem_q[4]     = 8'hD5;
        idle_q       = 8'h96;
    end

    // Data stands while the request stands, so the capture edge sees it
    assign nv_rdata_out = (nv_rd_en_in && idx < 16'h0005) ? mem_q[idx[2:0]] : idle_q;

    // Idle lines toggle so a missed capture shows
    always @(posedge mclk_in) begin
        idle_q <= ~idle_q;
    end
endmodule : opsc_nv_model

/* File: dv/tb.sv */
`timescale 1ns/10ps
module tb;
    import opsc_pkg::*;
    logic mclk_in = 1'b0, srst_in = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic rvalid, busy, nv_rd, gate, clamp, latched, xf, chop, gzero;
    logic [15:0] nv_addr;
    logic [7:0] nv_data, div_trim, dc_trim;
    logic signed [6:0] div_mv, diff_mv;
    logic sup_req = 1'b0, evt = 1'b0, lmode = 1'b0, ok_req = 1'b0;
    logic mains_req = 1'b0, gate_req = 1'b0, clamp_req = 1'b0;
    logic sup_pin, flt_pin, ok_pin, mains_pin;
    int mismatches = 0, samples_checked = 0;
    logic [7:0] pol_set [0:5] = '{8'hF0, 8'h00, 8'h80, 8'h48, 8'h24, 8'h1C};
    logic [7:0] nv_exp [0:4] = '{8'hC8, 8'h5A, 8'h3C, 8'hCA, 8'hD5};
    int mags1 [0:3] = '{5, 10, 20, 0};
    int mags2 [0:3] = '{8, 15, 30, 0};

    initial begin
        forever #5 mclk_in = ~mclk_in;
    end

    opsc_config_bank DUT (.mclk_in(mclk_in), .srst_in(srst_in), .host_wr_en_in(wr_en),
        .host_rd_en_in(rd_en), .host_addr_in(addr), .host_wdata_in(wdata),
        .host_rdata_out(rdata), .host_rvalid_out(rvalid), .cfg_busy_out(busy),
        .nv_rd_en_out(nv_rd), .nv_addr_out(nv_addr), .nv_rdata_in(nv_data),
        .supply_enable_req_in(sup_req), .fault_event_in(evt), .fault_latch_mode_in(lmode),
        .output_good_req_in(ok_req), .mains_good_req_in(mains_req),
        .gate_on_req_in(gate_req), .share_clamp_req_in(clamp_req),
        .supply_enable_out(sup_pin), .fault_indicator_out(flt_pin),
        .output_good_out(ok_pin), .mains_good_out(mains_pin), .pass_gate_out(gate),
        .share_clamp_out(clamp), .fault_latched_out(latched),
        .divider_error_trim_out(div_trim), .sense_dc_offset_trim_out(dc_trim),
        .divider_trim_mv_out(div_mv), .diff_trim_mv_out(diff_mv),
        .sense_xformer_mode_out(xf), .chopper_en_out(chop),
        .ground_offset_zero_out(gzero));

    opsc_nv_model NVM (.mclk_in(mclk_in), .nv_rd_en_in(nv_rd), .nv_addr_in(nv_addr),
        .nv_rdata_out(nv_data));

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : cycles

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk_in);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge mclk_in);
        rd_en <= 1'b0;
        #1;
        chk("rvalid", {7'h00, rvalid}, 8'h01);
        chk("rdata", rdata, exp);
    endtask : rd

    task automatic do_reset(input int n);
        int k;
        srst_in <= 1'b1;
        repeat (n) @(posedge mclk_in);
        srst_in <= 1'b0;
        repeat (8) @(posedge mclk_in);
        wr(OFS_OUT_POL, 8'h00);
        for (k = 0; k < 100 && busy !== 1'b0; k++) cycles(1);
        if (k == 100) begin
            mismatches++;
            summarize();
        end
    endtask : do_reset

    initial begin
        int i, c, lv;
        logic [7:0] cf;
        logic [6:0] e1, e2;
        do_reset(16);
        // ==========================================
        // Power-up load and trim outputs
        for (i = 0; i < 5; i++) rd(OFS_OUT_POL + 8'(i), nv_exp[i]);
        chk("div_trim", div_trim, 8'h5A);
        chk("dc_trim", dc_trim, 8'h3C);
        // ==========================================
        // Read back, reserved bits and unmapped places
        for (i = 0; i < 5; i++) begin
            wr(OFS_OUT_POL + 8'(i), 8'hA5 ^ 8'(i));
            rd(OFS_OUT_POL + 8'(i), 8'hA5 ^ 8'(i));
        end
        wr(8'h18, 8'hFF);
        rd(8'h18, UNMAPPED_READ);
        rd(8'h12, UNMAPPED_READ);
        chk("dc_trim_new", dc_trim, 8'hA7);
        // ==========================================
        // Pin polarity, gate and clamp
        for (i = 0; i < 6; i++) begin
            cf = pol_set[i];
            wr(OFS_OUT_POL, cf);
            for (lv = 0; lv < 2; lv++) begin
                {sup_req, evt, ok_req, mains_req, gate_req, clamp_req} <= {6{lv[0]}};
                cycles(3);
                e1 = {3'h0, lv[0] ? cf[7:4] : ~cf[7:4]};
                chk("pins", {4'h0, sup_pin, flt_pin, ok_pin, mains_pin}, {1'b0, e1});
                chk("gate", {7'h00, gate}, {7'h00, cf[3] ~^ lv[0]});
                chk("clamp", {7'h00, clamp}, {7'h00, cf[2] | lv[0]});
            end
        end
        {sup_req, evt, ok_req, mains_req, gate_req, clamp_req} <= 6'h00;
        // ==========================================
        // Host fault drive and latch
        wr(OFS_OUT_POL, 8'h42);
        cycles(3);
        chk("fault_drv", {7'h00, flt_pin}, 8'h01);
        wr(OFS_OUT_POL, 8'h02);
        cycles(3);
        chk("fault_drv_inv", {7'h00, flt_pin}, 8'h00);
        wr(OFS_OUT_POL, 8'h40);
        for (lv = 0; lv < 2; lv++) begin
            lmode <= lv[0];
            evt   <= 1'b1;
            cycles(1);
            evt <= 1'b0;
            cycles(4);
            chk("latched", {7'h00, latched}, {7'h00, lv[0]});
            chk("fault_hold", {7'h00, flt_pin}, {7'h00, lv[0]});
        end
        wr(OFS_OUT_POL, 8'h41);
        cycles(4);
        chk("latch_clr", {7'h00, latched}, 8'h00);
        chk("fault_clr", {7'h00, flt_pin}, 8'h00);
        wr(OFS_OUT_POL, 8'h40);
        lmode <= 1'b0;
        // ==========================================
        // Trim range codes and sense options
        for (c = 0; c < 8; c++) begin
            wr(OFS_SENSE_ONE, 8'hC2 | 8'(c << 3));
            wr(OFS_SENSE_TWO, {c[2], c[0], 1'b0, c[1], 1'b1, 3'(c)});
            cycles(2);
            e1 = c[2] ? 7'(mags1[c % 4]) : 7'(-mags1[c % 4]);
            e2 = c[2] ? 7'(mags2[c % 4]) : 7'(-mags2[c % 4]);
            chk("div_mv", {1'b0, div_mv}, {1'b0, e1});
            chk("diff_mv", {1'b0, diff_mv}, {1'b0, e2});
            chk("chopper", {7'h00, chop}, {7'h00, c[0]});
            chk("gnd_zero", {7'h00, gzero}, {7'h00, c[1]});
            chk("xformer", {7'h00, xf}, {7'h00, c[2]});
        end
        // ==========================================
        // Second reset reloads the stored copy
        @(posedge mclk_in);
        do_reset(2);
        for (i = 0; i < 5; i++) rd(OFS_OUT_POL + 8'(i), nv_exp[i]);
        summarize();
    end
endmodule : tb
